/* core/rfc_control.sv */
`timescale 1ns/1ps
`default_nettype none
module rfc_control #(
  parameter int DIV_W = 3  // Divider counter width
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Clock source ticks, same clock domain
  input  wire logic        internal_oscillator,
  input  wire logic        low_speed_crystal,
  input  wire logic        high_speed_oscillator,
  input  wire logic        external_clock_input,
  input  wire logic        debug_mode,
  // Pins from the analog side
  input  wire logic        cr_oscillation_clock,
  input  wire logic        external_count_input,
  // Outputs to the analog side
  output logic             reference_osc_on,
  output logic             sensor_a_osc_on,
  output logic             sensor_b_osc_on,
  output logic             ac_sensing,
  output logic             oscillation_monitor_pin,
  output logic             interrupt_request
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Divider hit: low sel bits of count all ones
  function automatic logic div_hit(input logic [DIV_W-1:0] cnt, input logic [1:0] sel);
    logic [DIV_W-1:0] mask;
    mask = DIV_W'((1 << sel) - 1);
    div_hit = ((cnt & mask) == mask);
  endfunction : div_hit

  // Byte-lane merge into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
    merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic                       debug_keep_q;    // Keep clock in debug
  logic [1:0]                 div_sel_q;       // Divider select
  logic [1:0]                 src_sel_q;       // Source select
  logic                       mon_halve_q;     // Monitor halve
  logic                       continuous_q;    // Continuous oscillate
  logic                       ext_count_q;     // External count mode
  logic [1:0]                 osc_type_q;      // Oscillation type
  logic                       block_en_q;      // Block enable
  logic [rfc_pkg::CNT_W-1:0]  meas_q;          // Measurement counter
  logic [rfc_pkg::CNT_W-1:0]  meas_d;
  logic [rfc_pkg::CNT_W-1:0]  tb_q;            // Time base counter
  logic [rfc_pkg::CNT_W-1:0]  tb_d;
  logic [rfc_pkg::NUM_FLAGS-1:0] flags_q;      // Event flags
  logic [rfc_pkg::NUM_FLAGS-1:0] flags_d;
  logic [rfc_pkg::NUM_FLAGS-1:0] enables_q;    // Event enables
  rfc_pkg::rfc_osc_t          osc_q;           // Oscillation state
  rfc_pkg::rfc_osc_t          osc_d;

  // ----------------------------------------------------------------
  // AXI write and read channel state
  // ----------------------------------------------------------------
  logic [7:0]  awaddr_q;   // Held write address
  logic        aw_have_q;  // Address captured
  logic [31:0] wdata_q;    // Held write data
  logic [3:0]  wstrb_q;    // Held strobes
  logic        w_have_q;   // Data captured
  logic        bvalid_q;   // Response pending
  logic [1:0]  bresp_q;    // Response code
  logic        rvalid_q;   // Read data pending
  logic [31:0] rdata_q;    // Read data
  logic [1:0]  rresp_q;    // Read response

  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_have_q & w_have_q & ~bvalid_q;
  wire ar_take  = s_axi_arvalid & s_axi_arready;

  assign s_axi_awready = ~aw_have_q & ~bvalid_q;
  assign s_axi_wready  = ~w_have_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Write address decode
  wire wr_clk   = do_write & (awaddr_q == rfc_pkg::OFS_CLOCK_SETUP);
  wire wr_ctl   = do_write & (awaddr_q == rfc_pkg::OFS_CONTROL);
  wire wr_trg   = do_write & (awaddr_q == rfc_pkg::OFS_TRIGGER);
  wire wr_ml    = do_write & (awaddr_q == rfc_pkg::OFS_MEAS_LOW);
  wire wr_mh    = do_write & (awaddr_q == rfc_pkg::OFS_MEAS_HIGH);
  wire wr_tl    = do_write & (awaddr_q == rfc_pkg::OFS_TB_LOW);
  wire wr_th    = do_write & (awaddr_q == rfc_pkg::OFS_TB_HIGH);
  wire wr_flg   = do_write & (awaddr_q == rfc_pkg::OFS_FLAGS);
  wire wr_ena   = do_write & (awaddr_q == rfc_pkg::OFS_ENABLES);
  wire wr_hit   = wr_clk | wr_ctl | wr_trg | wr_ml | wr_mh | wr_tl | wr_th | wr_flg | wr_ena;
  wire [15:0] wr_ctl_val = merge16({7'h00, mon_halve_q, continuous_q, ext_count_q,
                                    osc_type_q, 3'h0, block_en_q}, wdata_q, wstrb_q);
  wire [15:0] wr_clk_val = merge16({7'h00, debug_keep_q, 2'h0, div_sel_q, 2'h0,
                                    src_sel_q}, wdata_q, wstrb_q);
  wire [15:0] wr_trg_val = merge16(16'h0000, wdata_q, wstrb_q);
  wire [15:0] wr_ena_val = merge16({11'h000, enables_q}, wdata_q, wstrb_q);  // Enable merge
  wire        trg_lane   = wstrb_q[0];

  // ----------------------------------------------------------------
  // AXI write handshake
  // ----------------------------------------------------------------
  // Address and data taken in either order, answer after both
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      awaddr_q  <= 8'h00;
      aw_have_q <= 1'b0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= rfc_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
        aw_have_q <= 1'b1;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (w_take) begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? rfc_pkg::RESP_OKAY : rfc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  logic [15:0] rd_val;
  logic        rd_hit;
  wire  [7:0]  rd_addr = {s_axi_araddr[7:2], 2'b00};
  always_comb begin
    rd_hit = 1'b1;
    case (rd_addr)
      rfc_pkg::OFS_CLOCK_SETUP: rd_val = {7'h00, debug_keep_q, 2'h0, div_sel_q, 2'h0, src_sel_q};
      rfc_pkg::OFS_CONTROL: rd_val = {7'h00, mon_halve_q, continuous_q, ext_count_q,
                                      osc_type_q, 3'h0, block_en_q};
      rfc_pkg::OFS_TRIGGER: rd_val = {13'h0000, sensor_b_osc_on, sensor_a_osc_on,
                                      reference_osc_on};
      rfc_pkg::OFS_MEAS_LOW:  rd_val = meas_q[15:0];
      rfc_pkg::OFS_MEAS_HIGH: rd_val = {8'h00, meas_q[23:16]};
      rfc_pkg::OFS_TB_LOW:    rd_val = tb_q[15:0];
      rfc_pkg::OFS_TB_HIGH:   rd_val = {8'h00, tb_q[23:16]};
      rfc_pkg::OFS_FLAGS:     rd_val = {11'h000, flags_q};
      rfc_pkg::OFS_ENABLES:   rd_val = {11'h000, enables_q};
      default: begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read answer one cycle after address
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= rfc_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {16'h0000, rd_val};
      rresp_q  <= rd_hit ? rfc_pkg::RESP_OKAY : rfc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Clock setup follows writes only while the block is disabled
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      debug_keep_q <= rfc_pkg::DEBUG_KEEP_RST;
      div_sel_q    <= 2'h0;
      src_sel_q    <= rfc_pkg::SRC_INTERNAL;
      mon_halve_q  <= 1'b0;
      continuous_q <= 1'b0;
      ext_count_q  <= 1'b0;
      osc_type_q   <= rfc_pkg::OSC_TYPE_DC;
      block_en_q   <= 1'b0;
      enables_q    <= '0;
    end else begin
      if (wr_clk && !block_en_q) begin
        debug_keep_q <= wr_clk_val[rfc_pkg::BIT_DEBUG_KEEP];
        div_sel_q    <= wr_clk_val[rfc_pkg::POS_DIV +: 2];
        src_sel_q    <= wr_clk_val[rfc_pkg::POS_SRC +: 2];
      end
      if (wr_ctl) begin
        mon_halve_q  <= wr_ctl_val[rfc_pkg::BIT_MON_HALVE];
        continuous_q <= wr_ctl_val[rfc_pkg::BIT_CONTINUOUS];
        ext_count_q  <= wr_ctl_val[rfc_pkg::BIT_EXT_COUNT];
        osc_type_q   <= wr_ctl_val[rfc_pkg::POS_OSC_TYPE +: 2];
        block_en_q   <= wr_ctl_val[rfc_pkg::BIT_BLOCK_EN];
      end
      if (wr_ena) begin
        enables_q <= wr_ena_val[rfc_pkg::NUM_FLAGS-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Operating clock: source select and divider
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_cnt_q;  // Divider count
  logic             src_tick;   // Selected source pulse
  always_comb begin
    case (src_sel_q)
      rfc_pkg::SRC_INTERNAL: src_tick = internal_oscillator;
      rfc_pkg::SRC_LOW_XTAL: src_tick = low_speed_crystal;
      rfc_pkg::SRC_HIGH_OSC: src_tick = high_speed_oscillator;
      default:               src_tick = external_clock_input;
    endcase
  end
  wire divided  = (src_sel_q == rfc_pkg::SRC_INTERNAL) | (src_sel_q == rfc_pkg::SRC_HIGH_OSC);
  wire clk_run  = block_en_q & (~debug_mode | debug_keep_q);
  wire op_tick  = clk_run & src_tick & (~divided | div_hit(div_cnt_q, div_sel_q));

  // Divider advances on source pulses while running
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= '0;
    end else if (!clk_run) begin
      div_cnt_q <= '0;
    end else if (src_tick) begin
      div_cnt_q <= div_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic cr_s1_q, cr_s2_q, cr_s3_q;  // CR clock sync chain
  logic ex_s1_q, ex_s2_q, ex_s3_q;  // External input sync chain
  logic mon_div_q;                  // Halved monitor toggle
  logic mon_q;                      // Monitor pin register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cr_s1_q <= 1'b0;
      cr_s2_q <= 1'b0;
      cr_s3_q <= 1'b0;
      ex_s1_q <= 1'b0;
      ex_s2_q <= 1'b0;
      ex_s3_q <= 1'b0;
    end else begin
      cr_s1_q <= cr_oscillation_clock;
      cr_s2_q <= cr_s1_q;
      cr_s3_q <= cr_s2_q;
      ex_s1_q <= external_count_input;
      ex_s2_q <= ex_s1_q;
      ex_s3_q <= ex_s2_q;
    end
  end
  wire cr_rise  = cr_s2_q & ~cr_s3_q;
  wire ex_rise  = ex_s2_q & ~ex_s3_q;
  wire running  = (osc_q != rfc_pkg::OSC_IDLE);
  wire cnt_tick = running & clk_run & (ext_count_q ? ex_rise : cr_rise);

  // Monitor pin: CR clock or its half
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mon_div_q <= 1'b0;
      mon_q     <= 1'b0;
    end else begin
      if (cr_rise) begin
        mon_div_q <= ~mon_div_q;
      end
      mon_q <= mon_halve_q ? mon_div_q : cr_s2_q;
    end
  end
  assign oscillation_monitor_pin = mon_q;

  // ----------------------------------------------------------------
  // Oscillation sequencing and counters
  // ----------------------------------------------------------------
  wire trg_ok    = wr_trg & trg_lane & block_en_q;
  wire start_ref = trg_ok & wr_trg_val[rfc_pkg::BIT_REF_RUN];
  wire start_a   = trg_ok & wr_trg_val[rfc_pkg::BIT_SEN_A_RUN];
  wire start_b   = trg_ok & wr_trg_val[rfc_pkg::BIT_SEN_B_RUN] &
                   (osc_type_q != rfc_pkg::OSC_TYPE_AC);
  wire meas_ovf  = cnt_tick & (meas_q == rfc_pkg::CNT_MAX);
  wire tb_ovf    = op_tick & (tb_q == rfc_pkg::CNT_MAX);
  wire tb_zero   = op_tick & (tb_q == rfc_pkg::CNT_ONE);
  wire [rfc_pkg::NUM_FLAGS-1:0] clr_mask =
       wr_flg & wstrb_q[0] ? wdata_q[rfc_pkg::NUM_FLAGS-1:0] : '0;

  // Next counter, state and flag values
  always_comb begin
    meas_d  = meas_q;
    tb_d    = tb_q;
    osc_d   = osc_q;
    flags_d = flags_q & ~clr_mask;
    case (osc_q)
      rfc_pkg::OSC_REF: begin
        if (cnt_tick) meas_d = meas_q + rfc_pkg::CNT_ONE;
        if (op_tick) tb_d = tb_q + rfc_pkg::CNT_ONE;
        if (meas_ovf) flags_d[rfc_pkg::FLG_REF_DONE] = 1'b1;
        if (tb_ovf) flags_d[rfc_pkg::FLG_TB_OVF] = 1'b1;
        if ((meas_ovf | tb_ovf) && !continuous_q) osc_d = rfc_pkg::OSC_IDLE;
      end
      rfc_pkg::OSC_SEN_A, rfc_pkg::OSC_SEN_B: begin
        if (cnt_tick) meas_d = meas_q + rfc_pkg::CNT_ONE;
        if (op_tick) tb_d = tb_q - rfc_pkg::CNT_ONE;
        if (tb_zero) begin
          if (osc_q == rfc_pkg::OSC_SEN_A) flags_d[rfc_pkg::FLG_SEN_A_DONE] = 1'b1;
          else flags_d[rfc_pkg::FLG_SEN_B_DONE] = 1'b1;
        end
        if (meas_ovf) flags_d[rfc_pkg::FLG_MEAS_OVF] = 1'b1;
        if ((meas_ovf | tb_zero) && !continuous_q) osc_d = rfc_pkg::OSC_IDLE;
      end
      default: begin
        osc_d = rfc_pkg::OSC_IDLE;
      end
    endcase
    // Software trigger writes: 1 starts, 0 stops the running one
    if (trg_ok) begin
      if (start_ref) begin
        osc_d = rfc_pkg::OSC_REF;
        tb_d  = rfc_pkg::CNT_RST;
      end else if (start_a || start_b) begin
        osc_d  = start_a ? rfc_pkg::OSC_SEN_A : rfc_pkg::OSC_SEN_B;
        meas_d = rfc_pkg::CNT_RST;
      end else begin
        osc_d = rfc_pkg::OSC_IDLE;
      end
    end
    if (!block_en_q) osc_d = rfc_pkg::OSC_IDLE;
    // Software counter loads, low half then high half
    if (wr_ml) meas_d[15:0] = merge16(meas_q[15:0], wdata_q, wstrb_q);
    if (wr_mh && wstrb_q[0]) meas_d[23:16] = wdata_q[7:0];
    if (wr_tl) tb_d[15:0] = merge16(tb_q[15:0], wdata_q, wstrb_q);
    if (wr_th && wstrb_q[0]) tb_d[23:16] = wdata_q[7:0];
  end

  // State, counter and flag registers; events beat clears
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      osc_q   <= rfc_pkg::OSC_IDLE;
      meas_q  <= rfc_pkg::CNT_RST;
      tb_q    <= rfc_pkg::CNT_RST;
      flags_q <= '0;
    end else begin
      osc_q   <= osc_d;
      meas_q  <= meas_d;
      tb_q    <= tb_d;
      flags_q <= flags_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic irq_q;  // Registered request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flags_q & enables_q);
    end
  end
  assign interrupt_request = irq_q;
  assign reference_osc_on  = (osc_q == rfc_pkg::OSC_REF);
  assign sensor_a_osc_on   = (osc_q == rfc_pkg::OSC_SEN_A);
  assign sensor_b_osc_on   = (osc_q == rfc_pkg::OSC_SEN_B);
  assign ac_sensing        = (osc_type_q == rfc_pkg::OSC_TYPE_AC);

endmodule : rfc_control
`default_nettype wire

/* core/rfc_pkg.sv */
`default_nettype none
package rfc_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CLOCK_SETUP   = 8'h00;  // Clock setup
  localparam logic [7:0] OFS_CONTROL       = 8'h04;  // Channel control
  localparam logic [7:0] OFS_TRIGGER       = 8'h08;  // Oscillation trigger
  localparam logic [7:0] OFS_MEAS_LOW      = 8'h0C;  // Measurement count low
  localparam logic [7:0] OFS_MEAS_HIGH     = 8'h10;  // Measurement count high
  localparam logic [7:0] OFS_TB_LOW        = 8'h14;  // Time base count low
  localparam logic [7:0] OFS_TB_HIGH       = 8'h18;  // Time base count high
  localparam logic [7:0] OFS_FLAGS         = 8'h1C;  // Event flags
  localparam logic [7:0] OFS_ENABLES       = 8'h20;  // Event enables
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_DEBUG_KEEP   = 8;  // Clock setup: keep clock in debug
  localparam int POS_DIV          = 4;  // Clock setup: divider field low bit
  localparam int POS_SRC          = 0;  // Clock setup: source field low bit
  localparam int BIT_MON_HALVE    = 8;  // Control: monitor halve
  localparam int BIT_CONTINUOUS   = 7;  // Control: continuous oscillate
  localparam int BIT_EXT_COUNT    = 6;  // Control: external count mode
  localparam int POS_OSC_TYPE     = 4;  // Control: oscillation type low bit
  localparam int BIT_BLOCK_EN     = 0;  // Control: block enable
  localparam int BIT_REF_RUN      = 0;  // Trigger: reference
  localparam int BIT_SEN_A_RUN    = 1;  // Trigger: sensor A
  localparam int BIT_SEN_B_RUN    = 2;  // Trigger: sensor B
  localparam int FLG_REF_DONE     = 0;  // Flags: reference done
  localparam int FLG_SEN_A_DONE   = 1;  // Flags: sensor A done
  localparam int FLG_SEN_B_DONE   = 2;  // Flags: sensor B done
  localparam int FLG_MEAS_OVF     = 3;  // Flags: measurement overflow
  localparam int FLG_TB_OVF       = 4;  // Flags: time base overflow
  localparam int NUM_FLAGS        = 5;  // Number of event flags
  localparam int CNT_W            = 24; // Counter width
  localparam int HALF_W           = 16; // Low half width
  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_INTERNAL   = 2'h0;  // Internal oscillator
  localparam logic [1:0] SRC_LOW_XTAL   = 2'h1;  // Low-speed crystal
  localparam logic [1:0] SRC_HIGH_OSC   = 2'h2;  // High-speed oscillator
  localparam logic [1:0] SRC_EXTERNAL   = 2'h3;  // External clock input
  localparam logic [1:0] OSC_TYPE_DC    = 2'h0;  // DC resistive sensing
  localparam logic [1:0] OSC_TYPE_AC    = 2'h1;  // AC resistive sensing
  localparam logic       DEBUG_KEEP_RST = 1'b1;  // Debug keep reset value
  localparam logic [23:0] CNT_RST       = 24'h00_0000;  // Counter reset
  localparam logic [23:0] CNT_MAX       = 24'hFF_FFFF;  // Counter top
  localparam logic [23:0] CNT_ONE       = 24'h00_0001;  // Counter step
  localparam logic [1:0] RESP_OKAY      = 2'h0;  // AXI okay
  localparam logic [1:0] RESP_SLVERR    = 2'h2;  // AXI slave error
  // One-hot oscillation state
  typedef enum logic [3:0] {
    OSC_IDLE  = 4'b0001,
    OSC_REF   = 4'b0010,
    OSC_SEN_A = 4'b0100,
    OSC_SEN_B = 4'b1000
  } rfc_osc_t;
endpackage : rfc_pkg
`default_nettype wire

/* verif/rfc_control_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module rfc_control_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic ac_sensing,
  input wire logic interrupt_request,
  input wire logic reference_osc_on,
  input wire logic sensor_a_osc_on,
  input wire logic sensor_b_osc_on
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Both write halves taken together: response two edges later
  AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response not on time");
  AST_WR_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_RESP_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_AR_RDY: assert property (s_axi_arready != s_axi_rvalid) else $error("read ready wrong");
  AST_ONE_RUN: assert property ($onehot0({reference_osc_on, sensor_a_osc_on, sensor_b_osc_on}))
    else $error("two oscillations at once");
  AST_START_WR: assert property ($rose(reference_osc_on) || $rose(sensor_a_osc_on)
    |-> $rose(s_axi_bvalid)) else $error("oscillation started without a write");
  AST_NO_B_AC: assert property (ac_sensing |-> !$rose(sensor_b_osc_on))
    else $error("sensor b started in ac mode");
  // Main scenarios reached
  COV_REF: cover property ($fell(reference_osc_on));
  COV_SEN_A: cover property ($fell(sensor_a_osc_on));
  COV_IRQ: cover property ($rose(interrupt_request));
endmodule : rfc_control_assertions
bind rfc_control rfc_control_assertions u_rfc_control_assertions (.*);
`default_nettype wire

/* verif/rfc_cr_osc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rfc_cr_osc_model #(
  parameter int HALF_NS = 7  // Half period; larger values give a slow oscillator
) (
  input  wire logic run,
  output logic      cr_clk
);
  // Oscillates while an oscillation is on, rests low between runs
  initial cr_clk = 1'b0;
  always #(HALF_NS) cr_clk = run ? ~cr_clk : 1'b0;
endmodule : rfc_cr_osc_model
`default_nettype wire

/* verif/rfc_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rfc_control_tb;
  typedef struct {logic [7:0] a; logic [15:0] d, e; logic [1:0] r;} rfc_row_t;
  logic clock = 1'b0, rst_n = 1'b0, tick = 1'b0, debug_mode = 1'b0, cr_oscillation_clock;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, reference_osc_on, sensor_a_osc_on, sensor_b_osc_on;
  logic ac_sensing, oscillation_monitor_pin, interrupt_request;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  wire logic internal_oscillator = tick, low_speed_crystal = tick;
  wire logic high_speed_oscillator = tick, external_clock_input = tick;
  wire logic external_count_input = cr_oscillation_clock;
  int errors = 0, tests_run = 0;
  // Address, write data, expected read, expected response
  rfc_row_t rows [10] = '{'{8'h20, 16'h001F, 16'h001F, 2'h0}, '{8'h0C, 16'hABCD, 16'hABCD, 2'h0},
    '{8'h10, 16'hFF12, 16'h0012, 2'h0}, '{8'h14, 16'h1234, 16'h1234, 2'h0},
    '{8'h18, 16'hFF56, 16'h0056, 2'h0}, '{8'h00, 16'hFE32, 16'h0032, 2'h0},
    '{8'h04, 16'hFFF0, 16'h01F0, 2'h0}, '{8'h08, 16'h0001, 16'h0000, 2'h0},
    '{8'h1C, 16'h001F, 16'h0000, 2'h0}, '{8'h24, 16'hFFFF, 16'h0000, 2'h2}};
  rfc_control u_rfc_control (.*);
  rfc_cr_osc_model u_rfc_cr_osc_model (.run(reference_osc_on | sensor_a_osc_on | sensor_b_osc_on),
    .cr_clk(cr_oscillation_clock));
  initial forever #2.5 clock = ~clock;
  always @(posedge clock) tick <= ~tick;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Write: both halves offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    {s_axi_awaddr, s_axi_wdata} <= {a, 16'h0000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {rdat, rsp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic rc(input logic [7:0] a, input logic [15:0] e, input string n);
    axi_rd(a);
    chk(n, rdat, {16'h0000, e});
  endtask : rc
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // Watchdog against a hung handshake
  initial begin
    #100000;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      axi_wr(rows[i].a, rows[i].d);
      chk("write response", 32'(rsp), 32'(rows[i].r));
      rc(rows[i].a, rows[i].e, "read back");
      chk("read response", 32'(rsp), 32'(rows[i].r));
    end
    $display("register table done");
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rc(8'h00, 16'h0100, "setup after reset");
    rc(8'h10, 16'h0000, "count after reset");
    rc(8'h20, 16'h0000, "enables after reset");
    axi_wr(8'h04, 16'h0001);
    axi_wr(8'h00, 16'h0003);
    rc(8'h00, 16'h0100, "setup while enabled");
    axi_wr(8'h04, 16'h0011);
    chk("ac sensing", 32'(ac_sensing), 32'h0000_0001);
    axi_wr(8'h08, 16'h0004);
    rc(8'h08, 16'h0000, "sensor b in ac mode");
    $display("reset and lock tests done");
    axi_wr(8'h04, 16'h0001);
    axi_wr(8'h1C, 16'h001F);
    axi_wr(8'h0C, 16'hFFF0);
    axi_wr(8'h10, 16'h00FF);
    axi_wr(8'h20, 16'h0001);
    axi_wr(8'h08, 16'h0001);
    repeat (20) if (!oscillation_monitor_pin) @(posedge clock);
    chk("monitor pin", 32'(oscillation_monitor_pin), 32'h0000_0001);
    rc(8'h08, 16'h0001, "reference running");
    repeat (2000) if (!interrupt_request) @(posedge clock);
    rc(8'h1C, 16'h0001, "reference done flag");
    rc(8'h08, 16'h0000, "reference stopped");
    axi_wr(8'h1C, 16'h0001);
    rc(8'h1C, 16'h0000, "flag cleared");
    chk("request dropped", 32'(interrupt_request), 32'h0000_0000);
    axi_wr(8'h14, 16'h0003);
    axi_wr(8'h18, 16'h0000);
    axi_wr(8'h08, 16'h0002);
    repeat (2000) if (sensor_a_osc_on) @(posedge clock);
    rc(8'h1C, 16'h0002, "sensor a done flag");
    rc(8'h08, 16'h0000, "sensor a stopped");
    chk("masked request", 32'(interrupt_request), 32'h0000_0000);
    axi_wr(8'h04, 16'h0000);
    axi_wr(8'h00, 16'h0000);
    axi_wr(8'h04, 16'h0001);
    rc(8'h00, 16'h0000, "debug keep cleared");
    debug_mode <= 1'b1;
    axi_wr(8'h1C, 16'h001F);
    axi_wr(8'h14, 16'h0003);
    axi_wr(8'h08, 16'h0002);
    repeat (40) @(posedge clock);
    rc(8'h08, 16'h0002, "frozen in debug");
    debug_mode <= 1'b0;
    repeat (40) @(posedge clock);
    rc(8'h1C, 16'h0002, "resumed after debug");
    $display("oscillation tests done");
    end_of_test();
  end
endmodule : rfc_control_tb
`default_nettype wire
